// File: core/light_sensor_pkg.sv
// Constants and carriers shared by the light sensor register set
// Assumes a 200 MHz core clock and a two-wire serial link
package light_sensor_pkg;
  // Register addresses
  localparam logic [3:0] REG_POWER  = 4'h0;
  localparam logic [3:0] REG_SETUP  = 4'h1;
  localparam logic [3:0] REG_LTH_LO = 4'h2;
  localparam logic [3:0] REG_LTH_HI = 4'h3;
  localparam logic [3:0] REG_HTH_LO = 4'h4;
  localparam logic [3:0] REG_HTH_HI = 4'h5;
  localparam logic [3:0] REG_ALERT  = 4'h6;
  localparam logic [3:0] REG_RSV7   = 4'h7;
  localparam logic [3:0] REG_FTEST  = 4'h8;
  localparam logic [3:0] REG_RSV9   = 4'h9;
  localparam logic [3:0] REG_REV    = 4'ha;
  localparam logic [3:0] REG_BLOCK  = 4'hb;
  localparam logic [3:0] REG_CHA_LO = 4'hc;
  localparam logic [3:0] REG_CHA_HI = 4'hd;
  localparam logic [3:0] REG_CHB_LO = 4'he;
  localparam logic [3:0] REG_CHB_HI = 4'hf;
  // Pointer byte fields
  localparam int CMD_SEL_BIT = 7;
  localparam int CMD_CLR_BIT = 6;
  localparam int CMD_BLK_BIT = 4;
  // Reset values, masks, block count and power-up code
  localparam logic [7:0] PTR_RST     = 8'h00;
  localparam logic [1:0] POWER_RST   = 2'h0;
  localparam logic [7:0] SETUP_RST   = 8'h02;
  localparam logic [7:0] SETUP_MASK  = 8'h1b;
  localparam logic [7:0] BLOCK_COUNT = 8'h04;
  localparam logic [1:0] POWER_UP    = 2'h3;
  // Setup register fields
  localparam int GAIN_BIT   = 4;
  localparam int MANUAL_BIT = 3;
  localparam logic [1:0] INTEGRATION_PERIOD_SELECT_SHORT  = 2'h0;
  localparam logic [1:0] INTEGRATION_PERIOD_SELECT_MID    = 2'h1;
  localparam logic [1:0] INTEGRATION_PERIOD_SELECT_LONG   = 2'h2;
  localparam logic [1:0] INTEGRATION_PERIOD_SELECT_MANUAL = 2'h3;
  // Timing
  localparam int CLK_NS          = 5;
  localparam int INTEGRATION_PERIOD_SELECT_SHORT_US  = 13700;
  localparam int INTEGRATION_PERIOD_SELECT_MID_US    = 101000;
  localparam int INTEGRATION_PERIOD_SELECT_LONG_US   = 402000;
  localparam int INTEGRATION_PERIOD_SELECT_SHORT_CYC = INTEGRATION_PERIOD_SELECT_SHORT_US * 1000 / CLK_NS;
  localparam int INTEGRATION_PERIOD_SELECT_MID_CYC   = INTEGRATION_PERIOD_SELECT_MID_US * 1000 / CLK_NS;
  localparam int INTEGRATION_PERIOD_SELECT_LONG_CYC  = INTEGRATION_PERIOD_SELECT_LONG_US * 1000 / CLK_NS;
  localparam int TMR_W           = 27;

  typedef struct packed {
    logic [15:0] chan_b;
    logic [15:0] chan_a;
  } adc_pair_s;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       first;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_req;
  } link_evt_s;
endpackage

// File: core/i2c_byte_link.sv
// Two-wire slave byte engine: start/stop, address match, ack, bytes
// Assumes the core clock is many times the serial clock rate
`timescale 1ns/1ps
module i2c_byte_link
  import light_sensor_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Open-drain pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Register side
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] tx_data,
  output link_evt_s       evt
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RXB  = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TXB  = 5'b01000,
    ST_MACK = 5'b10000
  } link_state_e;

  link_state_e state_ff;
  logic [2:0]  scl_sync_ff;
  logic [2:0]  sda_sync_ff;
  logic [7:0]  shift_ff;
  logic [2:0]  bit_ff;
  logic        addr_ff;
  logic        read_ff;
  logic        first_ff;
  logic        drive_ff;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  // Stage 0 feeds stage 1 only; edges are taken from stages 1 and 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
    end
  end

  assign scl_rise  = scl_sync_ff[1] & ~scl_sync_ff[2];
  assign scl_fall  = ~scl_sync_ff[1] & scl_sync_ff[2];
  assign start_det = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[2] & ~sda_sync_ff[1];
  assign stop_det  = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[2] & sda_sync_ff[1];
  // Open drain: only ever pulls low
  assign sda_o     = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_ff   <= 3'h0;
      addr_ff  <= 1'b0;
      read_ff  <= 1'b0;
      first_ff <= 1'b0;
      drive_ff <= 1'b0;
      sda_oe   <= 1'b0;
      evt      <= '0;
    end else begin
      evt       <= '0;
      evt.start <= start_det;
      evt.stop  <= stop_det;
      if (start_det) begin
        state_ff <= ST_RXB;
        addr_ff  <= 1'b1;
        first_ff <= 1'b1;
        bit_ff   <= 3'h0;
        drive_ff <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (stop_det) begin
        state_ff <= ST_IDLE;
        sda_oe   <= 1'b0;
      end else begin
        unique case (state_ff)
          ST_IDLE: begin
          end
          ST_RXB: if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
            bit_ff   <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              addr_ff <= 1'b0;
              if (!addr_ff) begin
                evt.rx_valid <= 1'b1;
                evt.rx_data  <= {shift_ff[6:0], sda_sync_ff[1]};
                evt.first    <= first_ff;
                first_ff     <= 1'b0;
                state_ff     <= ST_ACK;
              end else if (shift_ff[6:0] == dev_addr) begin
                read_ff    <= sda_sync_ff[1];
                evt.tx_req <= sda_sync_ff[1];
                evt.first  <= 1'b1;
                state_ff   <= ST_ACK;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_ACK: if (scl_fall) begin
            if (!drive_ff) begin
              drive_ff <= 1'b1;
              sda_oe   <= 1'b1;
            end else begin
              drive_ff <= 1'b0;
              bit_ff   <= 3'h0;
              if (read_ff) begin
                state_ff <= ST_TXB;
                sda_oe   <= ~tx_data[7];
                shift_ff <= {tx_data[6:0], 1'b0};
              end else begin
                state_ff <= ST_RXB;
                sda_oe   <= 1'b0;
              end
            end
          end
          ST_TXB: if (scl_fall) begin
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              sda_oe   <= 1'b0;
              state_ff <= ST_MACK;
            end else begin
              sda_oe   <= ~shift_ff[7];
              shift_ff <= {shift_ff[6:0], 1'b0};
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // A nack ends the read; the stop follows from the master
              if (sda_sync_ff[1]) begin
                state_ff <= ST_IDLE;
              end else begin
                evt.tx_req <= 1'b1;
                drive_ff   <= 1'b1;
              end
            end else if (scl_fall && drive_ff) begin
              drive_ff <= 1'b0;
              bit_ff   <= 3'h0;
              state_ff <= ST_TXB;
              sda_oe   <= ~tx_data[7];
              shift_ff <= {tx_data[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end
endmodule // i2c_byte_link

// File: core/light_sensor_register_set.sv
// Register set of a two-channel light converter behind a two-wire slave
// Assumes the analog front end returns results on adc_in when integration_period_select_end pulses
`timescale 1ns/1ps

// Functional notes
// - Power control at 0h, setup at 1h, alert setup at 6h, sixteen slots.
// - Slots 7h, 9h, Bh reserved; 8h factory test; all read zero.
// - Pointer written first; following reads and writes target that register.
// - Pointer is eight bits and zero after reset.
// - Block flag with pointer 9Bh: device sends count 4 before data.
// - The only block read is the four channel result bytes.
// - Plain reads keep supplying bytes until the host ends them.
// - Power field in bits 1:0; bits 7:2 are written as zero.
// - After writing 03h to power control, it reads back 03h.
// - One setup register drives both channels; reset value 02h.
// - Integration field: 13.7 ms, 101 ms, 402 ms, or manual.
// - Manual bit 1 starts integration, 0 ends it.
// - Interrupt when channel A result is at or below low threshold.
// - Interrupt when channel A result exceeds high threshold.
// - Low threshold bytes at 2h/3h, high threshold bytes at 4h/5h.
// - A first byte with its top bit set becomes the pointer.
// - Results: channel A at Ch/Dh, channel B at Eh/Fh.
// - Pointer address is the low four bits of that byte.
// - Reading a low result byte captures its high byte in a shadow.
// - Starts powered down; 03h powers up and starts converting.
module light_sensor_register_set
  import light_sensor_pkg::*;
#(
  parameter int         SHORT_CYC = INTEGRATION_PERIOD_SELECT_SHORT_CYC,
  parameter int         MID_CYC   = INTEGRATION_PERIOD_SELECT_MID_CYC,
  parameter int         LONG_CYC  = INTEGRATION_PERIOD_SELECT_LONG_CYC,
  parameter logic [6:0] DEV_ADDR  = 7'h29,
  // Arbitrary value
  parameter logic [7:0] PART_REV  = 8'h5a
)(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rstn,
  // Two-wire pins
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe,
  // Converter front end
  input  wire adc_pair_s adc_in,
  output logic           integrating,
  output logic           integration_period_select_end,
  output logic           gain_high,
  output logic           powered,
  // Interrupt
  output logic           int_n
);
  if (SHORT_CYC < 1 || MID_CYC < 1 || LONG_CYC < 1 || LONG_CYC >= (1 << TMR_W)) begin : g_chk
    $error("integration cycle counts out of range");
  end

  logic [1:0]       rst_sync_ff;
  logic             rst_n;
  link_evt_s        evt;
  logic [7:0]       pointer_ff;
  logic [3:0]       cursor_ff;
  logic             skip_ff;
  logic [1:0]       power_ff;
  logic [7:0]       setup_ff;
  logic [15:0]      low_th_ff;
  logic [15:0]      high_th_ff;
  logic [5:0]       alert_ff;
  adc_pair_s        result_ff;
  logic [7:0]       shadow_ff;
  logic [7:0]       tx_ff;
  logic [7:0]       rd_val;
  logic [3:0]       rd_addr;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] period;
  logic             integration_period_select_end_ff;
  logic             integrating_ff;
  logic             manual_d_ff;
  logic             int_ff;
  logic             cmd_byte;
  logic             data_wr;
  logic             rd_first;
  logic             blk_sel;
  logic             blk_count;
  logic             is_up;
  logic             manual_mode;
  logic             int_set;
  logic             int_clr;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  i2c_byte_link u_link (
    .clk      (clk),
    .rst_n    (rst_n),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .dev_addr (DEV_ADDR),
    .tx_data  (tx_ff),
    .evt      (evt)
  );

  // Decode of link events
  assign cmd_byte  = evt.rx_valid & evt.first & evt.rx_data[CMD_SEL_BIT];
  assign data_wr   = evt.rx_valid & ~evt.first & ~skip_ff;
  assign rd_first  = evt.tx_req & evt.first;
  assign blk_sel   = pointer_ff[CMD_BLK_BIT] & (pointer_ff[3:0] == REG_BLOCK);
  assign blk_count = rd_first & blk_sel;
  assign rd_addr   = rd_first ? pointer_ff[3:0] : cursor_ff;

  // Pointer and byte cursor; a first byte with top bit clear is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_ff <= PTR_RST;
      cursor_ff  <= 4'h0;
      skip_ff    <= 1'b0;
    end else if (cmd_byte) begin
      pointer_ff <= evt.rx_data;
      cursor_ff  <= evt.rx_data[3:0];
      // A block write carries a count byte first, which is not data
      skip_ff    <= evt.rx_data[CMD_BLK_BIT];
    end else if (evt.rx_valid) begin
      skip_ff <= 1'b0;
      if (data_wr) begin
        cursor_ff <= cursor_ff + 4'h1;
      end
    end else if (blk_count) begin
      cursor_ff <= REG_CHA_LO;
    end else if (evt.tx_req) begin
      cursor_ff <= rd_addr + 4'h1;
    end
  end

  // Writable registers; reserved, test, revision and results ignore writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ff   <= POWER_RST;
      setup_ff   <= SETUP_RST;
      low_th_ff  <= 16'h0000;
      high_th_ff <= 16'h0000;
      alert_ff   <= 6'h00;
    end else if (data_wr) begin
      case (cursor_ff)
        REG_POWER:  power_ff <= evt.rx_data[1:0];
        REG_SETUP:  setup_ff <= evt.rx_data & SETUP_MASK;
        REG_LTH_LO: low_th_ff[7:0] <= evt.rx_data;
        REG_LTH_HI: low_th_ff[15:8] <= evt.rx_data;
        REG_HTH_LO: high_th_ff[7:0] <= evt.rx_data;
        REG_HTH_HI: high_th_ff[15:8] <= evt.rx_data;
        REG_ALERT:  alert_ff <= evt.rx_data[5:0];
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer; high result bytes come only from the shadow
  always_comb begin
    rd_val = 8'h00;
    case (rd_addr)
      REG_POWER:  rd_val = {6'h00, power_ff};
      REG_SETUP:  rd_val = setup_ff;
      REG_LTH_LO: rd_val = low_th_ff[7:0];
      REG_LTH_HI: rd_val = low_th_ff[15:8];
      REG_HTH_LO: rd_val = high_th_ff[7:0];
      REG_HTH_HI: rd_val = high_th_ff[15:8];
      REG_ALERT:  rd_val = {2'b00, alert_ff};
      REG_REV:    rd_val = PART_REV;
      REG_CHA_LO: rd_val = result_ff.chan_a[7:0];
      REG_CHB_LO: rd_val = result_ff.chan_b[7:0];
      REG_CHA_HI: rd_val = shadow_ff;
      REG_CHB_HI: rd_val = shadow_ff;
      default:    rd_val = 8'h00;
    endcase
  end

  // Byte handed to the link; loaded well before the serial clock needs it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ff     <= 8'h00;
      shadow_ff <= 8'h00;
    end else if (blk_count) begin
      tx_ff <= BLOCK_COUNT;
    end else if (evt.tx_req) begin
      tx_ff <= rd_val;
      if (rd_addr == REG_CHA_LO) begin
        shadow_ff <= result_ff.chan_a[15:8];
      end else if (rd_addr == REG_CHB_LO) begin
        shadow_ff <= result_ff.chan_b[15:8];
      end
    end
  end

  // Integration timing shared by both channels
  assign is_up       = power_ff == POWER_UP;
  assign manual_mode = setup_ff[1:0] == INTEGRATION_PERIOD_SELECT_MANUAL;

  always_comb begin
    unique case (setup_ff[1:0])
      INTEGRATION_PERIOD_SELECT_SHORT:  period = SHORT_CYC[TMR_W-1:0];
      INTEGRATION_PERIOD_SELECT_MID:    period = MID_CYC[TMR_W-1:0];
      INTEGRATION_PERIOD_SELECT_LONG:   period = LONG_CYC[TMR_W-1:0];
      INTEGRATION_PERIOD_SELECT_MANUAL: period = LONG_CYC[TMR_W-1:0];
    endcase
  end

  // Changing the period mid-cycle may cut one period short; the next is exact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff <= '0;
    end else if (!is_up || manual_mode || tmr_ff >= period - 1'b1) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= tmr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integration_period_select_end_ff   <= 1'b0;
      integrating_ff <= 1'b0;
      manual_d_ff    <= 1'b0;
    end else begin
      manual_d_ff    <= is_up & manual_mode & setup_ff[MANUAL_BIT];
      integrating_ff <= is_up & (~manual_mode | setup_ff[MANUAL_BIT]);
      integration_period_select_end_ff   <= is_up & (manual_mode
                        ? (manual_d_ff & ~setup_ff[MANUAL_BIT])
                        : (tmr_ff >= period - 1'b1));
    end
  end

  // Results are taken as a pair; a block read can still take channel B from a later conversion than A
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= '0;
    end else if (integration_period_select_end_ff) begin
      result_ff <= adc_in;
    end
  end

  // Threshold interrupt on channel A; a set in the clear cycle wins
  assign int_set = integration_period_select_end_ff & (alert_ff[5:4] != 2'b00)
                   & ((adc_in.chan_a <= low_th_ff)
                   | (adc_in.chan_a > high_th_ff));
  assign int_clr = cmd_byte & evt.rx_data[CMD_CLR_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= int_set | (int_ff & ~int_clr);
    end
  end

  assign int_n       = ~int_ff;
  assign integrating = integrating_ff;
  assign integration_period_select_end   = integration_period_select_end_ff;
  assign gain_high   = setup_ff[GAIN_BIT];
  assign powered     = is_up;

  AST_PTR_RESET: assert property (
    @(posedge clk) $rose(rst_n) |-> pointer_ff == 8'h00)
    else $error("pointer not zero after reset");

  AST_SETUP_RESET: assert property (
    @(posedge clk) $rose(rst_n) |-> setup_ff == 8'h02 && power_ff == 2'h0)
    else $error("setup or power reset value wrong");

  AST_PTR_LOAD: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_byte |=> pointer_ff[3:0] == $past(evt.rx_data[3:0]) && cursor_ff == pointer_ff[3:0])
    else $error("pointer not loaded from command byte");

  AST_POWER_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_first && !blk_sel && pointer_ff[3:0] == 4'h0 |=> tx_ff == {6'h00, power_ff})
    else $error("power control readback wrong");

  AST_BLOCK_COUNT: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_first && pointer_ff == 8'h9b |=> tx_ff == 8'h04 && cursor_ff == 4'hc)
    else $error("block read count not inserted");

  AST_SHADOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.tx_req && !blk_count && rd_addr == 4'hc
    |=> shadow_ff == $past(result_ff.chan_a[15:8]))
    else $error("shadow not captured on low byte read");

  AST_LOW_INT: assert property (
    @(posedge clk) disable iff (!rst_n)
    integration_period_select_end_ff && alert_ff[5:4] != 2'b00 && adc_in.chan_a <= low_th_ff ##1 !int_clr
    |-> !int_n ##1 !int_n)
    else $error("low threshold interrupt missing");

  AST_HIGH_INT: assert property (
    @(posedge clk) disable iff (!rst_n)
    integration_period_select_end_ff && alert_ff[5:4] != 2'b00 && adc_in.chan_a > high_th_ff |=> !int_n)
    else $error("high threshold interrupt missing");

  AST_POWER_DOWN: assert property (
    @(posedge clk) disable iff (!rst_n)
    power_ff == 2'h0 |=> !integration_period_select_end_ff && !integrating_ff && tmr_ff == '0)
    else $error("activity while powered down");

  AST_SHORT_PERIOD: assert property (
    @(posedge clk) disable iff (!rst_n)
    is_up && setup_ff[1:0] == 2'h0 && $stable(setup_ff) && $stable(power_ff)
    && tmr_ff == SHORT_CYC - 1 |=> integration_period_select_end_ff ##1 !integration_period_select_end_ff)
    else $error("short integration end misplaced");

  AST_MANUAL_END: assert property (
    @(posedge clk) disable iff (!rst_n)
    is_up && manual_mode && $stable(power_ff) && $stable(setup_ff[1:0])
    && $fell(setup_ff[MANUAL_BIT]) |=> integration_period_select_end_ff ##1 !integration_period_select_end_ff)
    else $error("manual stop gave no single end pulse");

  AST_RESERVED_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.tx_req && !blk_count && (rd_addr == REG_RSV7 || rd_addr == REG_FTEST
    || rd_addr == REG_RSV9 || rd_addr == REG_BLOCK) |=> tx_ff == 8'h00)
    else $error("reserved location read not zero");

  AST_INT_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !int_n && !int_clr |=> !int_n)
    else $error("interrupt dropped without a clear");

  AST_POWER_UP: assert property (
    @(posedge clk) disable iff (!rst_n)
    data_wr && cursor_ff == REG_POWER && evt.rx_data == 8'h03 |=> powered)
    else $error("power-up write did not power the converter");
endmodule // light_sensor_register_set

// File: bench/smbus_host.sv
// Two-wire host model: makes the serial clock and pulls the data wire low
// Assumes a pull-up outside resolves the data wire; the clock stands high between frames
`timescale 1ns/1ps
module smbus_host #(
  parameter logic [6:0] ADDR = 7'h29
)(
  // Wire levels
  output logic      scl,
  output logic      sda_lo,
  input  wire logic sda
);
  // Quarter of a 64 ns serial period
  localparam time Q = 16;
  logic smp;
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
    smp = 1'b1;
  end
  task automatic bit_io(input logic x);
    #Q sda_lo = !x;
    #Q scl = 1'b1;
    #Q smp = sda;
    #Q scl = 1'b0;
  endtask
  // Also a repeated start: data is let go well before the clock rises
  task automatic start();
    sda_lo = 1'b0;
    #(2*Q) scl = 1'b1;
    #Q sda_lo = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_lo = 1'b1;
    #Q scl = 1'b1;
    #Q sda_lo = 1'b0;
    #(2*Q);
  endtask
  task automatic put(input logic [7:0] b, inout int nak);
    for (int i = 7; i >= 0; i--) bit_io(b[i]);
    bit_io(1'b1);
    nak += int'(smp);
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1);
      b[i] = smp;
    end
    bit_io(last);
  endtask
  // Command byte, then n data bytes low byte first; never a write at Bh
  task automatic wr(input logic [7:0] cmd, input int n, input logic [31:0] d, output int nak);
    nak = 0;
    start();
    put({ADDR, 1'b0}, nak);
    put(cmd, nak);
    for (int i = 0; i < n; i++) put(d[8*i +: 8], nak);
    stop();
  endtask
  // Optional pointer load, then n bytes with a nack on the last
  task automatic rd(input logic [7:0] cmd, input logic pre, input int n,
                    output logic [39:0] q, output int nak);
    logic [7:0] t;
    nak = 0;
    q = '0;
    start();
    if (pre) begin
      put({ADDR, 1'b0}, nak);
      put(cmd, nak);
      start();
    end
    put({ADDR, 1'b1}, nak);
    for (int i = 0; i < n; i++) begin
      get(i == n - 1, t);
      q[8*i +: 8] = t;
    end
    stop();
  endtask
endmodule // smbus_host

// File: bench/light_sensor_register_set_tb.sv
// Self-checking bench for the light sensor register set
// Assumes the host model on the two-wire pins and a pull-up on data
`timescale 1ns/1ps
module light_sensor_register_set_tb;
  import light_sensor_pkg::*;
  // Well above the roughly 13k cycles the tests need
  localparam int LIMIT = 40000;
  logic        clk;
  logic        rstn;
  logic        scl;
  logic        host_lo;
  logic        sda_o;
  logic        sda_oe;
  logic        sda;
  adc_pair_s   adc_in;
  logic        integrating;
  logic        integration_period_select_end;
  logic        gain_high;
  logic        powered;
  logic        int_n;
  int          errors;
  int          samples_checked;
  int          cycles;
  int          nak;
  int          k;
  logic [39:0] q;

  // Open drain: low while either party pulls
  assign sda = !(host_lo || sda_oe);

  light_sensor_register_set #(.SHORT_CYC(20), .MID_CYC(40), .LONG_CYC(60))
    light_sensor_register_set_i (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .adc_in(adc_in), .integrating(integrating),
    .integration_period_select_end(integration_period_select_end), .gain_high(gain_high), .powered(powered), .int_n(int_n));
  smbus_host smbus_host_i (.scl(scl), .sda_lo(host_lo), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      $display("Error %0t timeout", $time);
      final_report();
    end
  end

  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask
  // Start off the sampling edge so host moves never meet a rising edge
  task automatic w(input logic [7:0] cmd, input int n, input logic [31:0] d);
    @(negedge clk);
    smbus_host_i.wr(cmd, n, d, nak);
    chk(40'(nak), '0, "write ack");
  endtask
  task automatic r(input logic [7:0] cmd, input logic pre, input int n,
                   input logic [39:0] exp, input string what);
    @(negedge clk);
    smbus_host_i.rd(cmd, pre, n, q, nak);
    chk(q, exp, what);
  endtask
  // Wait for an end pulse, then two cycles for its effects to land
  task automatic wend();
    k = 0;
    while (integration_period_select_end !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk({39'h0, integration_period_select_end}, 40'h1, "end pulse");
    repeat (2) @(negedge clk);
  endtask

  initial begin
    rstn = 1'b0;
    adc_in = {16'h3344, 16'h1122};
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    r(8'h00, 1'b0, 1, 40'h00, "pointer");
    r(8'h81, 1'b1, 1, 40'h02, "setup");
    chk({39'h0, powered}, 40'h0, "off");
    chk({39'h0, sda_o}, 40'h0, "open drain");
    $display("Test reset done");
    w(8'h80, 1, 32'h03);
    r(8'h80, 1'b1, 1, 40'h03, "power");
    chk({38'h0, powered, integrating}, 40'h3, "on");
    w(8'h87, 4, 32'hffffffff);
    r(8'h87, 1'b1, 5, 40'h00_5a_00_00_00, "reserved");
    w(8'h82, 2, 32'h1121);
    w(8'h84, 2, 32'h1122);
    w(8'h86, 1, 32'h10);
    r(8'h82, 1'b1, 5, 40'h10_11_22_11_21, "thresholds");
    wend();
    wend();
    chk({39'h0, int_n}, 40'h1, "in window");
    $display("Test registers done");
    r(8'h9b, 1'b1, 5, 40'h33_44_11_22_04, "block");
    r(8'h8c, 1'b1, 1, 40'h22, "low byte");
    @(posedge clk) adc_in <= {16'h7788, 16'h5566};
    wend();
    r(8'h8d, 1'b1, 1, 40'h11, "shadow");
    chk({39'h0, int_n}, 40'h0, "above high");
    w(8'h8e, 0, 32'h0);
    r(8'h00, 1'b0, 2, 40'h7788, "send byte");
    w(8'h84, 2, 32'hffff);
    @(posedge clk) adc_in <= {16'h7788, 16'h1121};
    w(8'hc0, 0, 32'h0);
    wend();
    chk({39'h0, int_n}, 40'h0, "at low");
    w(8'h82, 2, 32'h1120);
    w(8'hc0, 0, 32'h0);
    wend();
    chk({39'h0, int_n}, 40'h1, "cleared");
    $display("Test data and interrupt done");
    for (int f = 0; f < 3; f++) begin
      w(8'h81, 1, 32'h10 + 32'(f));
      wend();
      // Two cycles of the period have already passed inside wend
      k = 2;
      while (integration_period_select_end !== 1'b1 && k < 200) begin
        @(negedge clk);
        k++;
      end
      chk(40'(k), 40'(20 * (f + 1)), "period");
      chk({39'h0, gain_high}, 40'h1, "gain");
    end
    w(8'h81, 1, 32'h03);
    chk({39'h0, integrating}, 40'h0, "manual idle");
    w(8'h81, 1, 32'h0b);
    chk({39'h0, integrating}, 40'h1, "manual run");
    @(posedge clk) adc_in <= {16'h0000, 16'h0abc};
    w(8'h81, 1, 32'h03);
    chk({39'h0, integrating}, 40'h0, "manual stop");
    r(8'h8c, 1'b1, 1, 40'hbc, "manual result");
    w(8'h80, 1, 32'h00);
    chk({38'h0, powered, integrating}, 40'h0, "down");
    $display("Test timing and power done");
    final_report();
  end
endmodule // light_sensor_register_set_tb
